// File: core/rnb_net_busy.sv
`timescale 1ns/10ps
module rnb_net_busy
#(
   parameter int unsigned MS_DIVIDE = rnb_pkg::CLKS_PER_MS
)
(
   input  wire logic                   clk_sys,
   input  wire logic                   arst_n,
   input  wire logic                   bitStb,
   input  wire logic                   indOn,
   input  wire logic                   rxBit,
   input  wire logic                   frequency_hop_mode,
   input  wire logic                   txReq,
   input  wire logic                   txDataValid,
   input  wire logic                   txDataBit,
   input  wire logic                   txDataLast,
   output      logic                   txDataReady,
   input  wire logic                   frmPrecValid,
   input  wire logic [2:0]             frmPrec,
   output      logic                   precWrValid,
   output      logic [2:0]             precWrValue,
   input  wire logic                   precWrReady,
   output      logic                   ctrlOn,
   output      logic                   txLine,
   output      logic                   txBusy,
   output      logic                   txDone,
   output      logic [5:0]             slotWidthMs,
   output      rnb_pkg::rnb_status_type status,
   output      rnb_pkg::rnb_adjust_type timerAdjust
);
   import rnb_pkg::*;

   // =====================================================
   // millisecond tick
   logic [31:0] msCnt_q;
   logic        msTick_q;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         msCnt_q  <= 32'h0;
         msTick_q <= 1'b0;
      end
      else if (msCnt_q == MS_DIVIDE - 1)
      begin
         msCnt_q  <= 32'h0;
         msTick_q <= 1'b1;
      end
      else
      begin
         msCnt_q  <= msCnt_q + 32'h1;
         msTick_q <= 1'b0;
      end

   // =====================================================
   // receive line pattern sense
   logic [7:0] rxShift_q;
   logic [3:0] onesRun_q;
   logic       rFlags_q;
   logic       rOnes;

   assign rOnes = (onesRun_q >= ONES_RUN_MIN);

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         rxShift_q <= 8'hFF;
         onesRun_q <= 4'hF;
         rFlags_q  <= 1'b0;
      end
      else if (bitStb)
      begin
         rxShift_q <= {rxShift_q[6:0], rxBit};
         if (!rxBit)
            onesRun_q <= 4'h0;
         else if (onesRun_q != 4'hF)
            onesRun_q <= onesRun_q + 4'h1;
         if ({rxShift_q[6:0], rxBit} == FLAG_PATTERN)
            rFlags_q <= 1'b1;
         else if (rOnes)
            rFlags_q <= 1'b0;
      end

   // =====================================================
   // channel state
   rnb_chan_type         chan_q;
   logic [BUSY_MS_W-1:0] busyMs_q;
   logic                 adjValid_q;
   logic [BUSY_MS_W-1:0] adjMs_q;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         chan_q <= CH_IDLE;
      else if (!indOn)
      begin
         if (rFlags_q)
            chan_q <= CH_OWN_TX;
         else if (rOnes)
            chan_q <= CH_IDLE;
         else if (chan_q != CH_OWN_TX)
            chan_q <= CH_IDLE;
      end
      else
      begin
         unique case (chan_q)
            CH_IDLE, CH_OWN_TX:
               chan_q <= rFlags_q ? CH_DATA_RX : CH_BUSY_UNKNOWN;
            CH_BUSY_UNKNOWN:
               if (rFlags_q)
                  chan_q <= CH_DATA_RX;
               else if (msTick_q && busyMs_q == BUSY_MS_W'(VOICE_WINDOW_MS - 1))
                  chan_q <= CH_VOICE;
            CH_DATA_RX:
               chan_q <= CH_DATA_RX;
            CH_VOICE:
               chan_q <= rFlags_q ? CH_DATA_RX : CH_VOICE;
            default:
               chan_q <= CH_IDLE;
         endcase
      end

   // busy duration measured until voice is decided
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         busyMs_q <= '0;
      else if (chan_q != CH_BUSY_UNKNOWN)
         busyMs_q <= '0;
      else if (msTick_q)
         busyMs_q <= busyMs_q + 1'b1;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         adjValid_q <= 1'b0;
         adjMs_q    <= '0;
      end
      else
      begin
         adjValid_q <= (chan_q == CH_BUSY_UNKNOWN) && indOn && !rFlags_q && msTick_q
                       && busyMs_q == BUSY_MS_W'(VOICE_WINDOW_MS - 1);
         adjMs_q    <= busyMs_q + 1'b1;
      end

   assign status.chan    = chan_q;
   assign status.busy    = (chan_q == CH_BUSY_UNKNOWN) || (chan_q == CH_DATA_RX)
                           || (chan_q == CH_VOICE);
   assign status.voice   = (chan_q == CH_VOICE);
   assign status.suspend = (chan_q == CH_VOICE);
   assign timerAdjust.valid = adjValid_q;
   assign timerAdjust.addMs = adjMs_q;
   assign slotWidthMs = frequency_hop_mode ? 6'(SLOT_HOP_MS) : 6'(SLOT_SINGLE_MS);

   // =====================================================
   // precedence tracking
   logic [2:0] maxPrec_q;
   logic [2:0] progPrec_q;
   logic       precWr_q;
   rnb_tx_type tx_q;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
         maxPrec_q <= PREC_RESET;
      else if (txReq && tx_q == TX_IDLE)
         maxPrec_q <= (frmPrecValid) ? frmPrec : PREC_RESET;
      else if (frmPrecValid && frmPrec > maxPrec_q)
         maxPrec_q <= frmPrec;

   // =====================================================
   // keying sequence
   logic [2:0] flagIdx_q;
   logic       ctrl_q;
   logic       tLine_q;
   logic       done_q;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         tx_q       <= TX_IDLE;
         precWr_q   <= 1'b0;
         progPrec_q <= PREC_RESET;
      end
      else
      begin
         unique case (tx_q)
            TX_IDLE:
               if (txReq)
               begin
                  if (maxPrec_q != progPrec_q)
                  begin
                     tx_q       <= TX_PREC;
                     precWr_q   <= 1'b1;
                     progPrec_q <= maxPrec_q;
                  end
                  else
                     tx_q <= TX_WAIT_CLEAR;
               end
            TX_PREC:
               if (precWrReady)
               begin
                  precWr_q <= 1'b0;
                  tx_q     <= TX_WAIT_CLEAR;
               end
            TX_WAIT_CLEAR:
               if (!indOn && rOnes && !rFlags_q)
                  tx_q <= TX_FLAGS;
            TX_FLAGS:
               if (bitStb && flagIdx_q == 3'h7 && !indOn && rFlags_q)
                  tx_q <= TX_DATA;
            TX_DATA:
               if (bitStb && txDataValid && txDataLast)
                  tx_q <= TX_TAIL;
            TX_TAIL:
               if (bitStb)
                  tx_q <= TX_IDLE;
         endcase
      end

   assign txDataReady = (tx_q == TX_DATA) && bitStb;
   assign precWrValid = precWr_q;
   assign precWrValue = progPrec_q;

   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n)
      begin
         ctrl_q    <= 1'b0;
         tLine_q   <= 1'b1;
         flagIdx_q <= 3'h0;
         done_q    <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (tx_q == TX_WAIT_CLEAR && !indOn && rOnes && !rFlags_q)
         begin
            ctrl_q    <= 1'b1;
            flagIdx_q <= 3'h0;
         end
         else if (bitStb)
         begin
            unique case (tx_q)
               TX_FLAGS:
               begin
                  tLine_q   <= FLAG_PATTERN[3'h7 - flagIdx_q];
                  flagIdx_q <= flagIdx_q + 3'h1;
               end
               TX_DATA:
               begin
                  if (txDataValid)
                     tLine_q <= txDataBit;
                  else
                  begin
                     tLine_q   <= FLAG_PATTERN[3'h7 - flagIdx_q];
                     flagIdx_q <= flagIdx_q + 3'h1;
                  end
               end
               TX_TAIL:
               begin
                  ctrl_q  <= 1'b0;
                  tLine_q <= 1'b1;
                  done_q  <= 1'b1;
               end
               default:
                  tLine_q <= 1'b1;
            endcase
         end
      end

   assign ctrlOn = ctrl_q;
   assign txLine = tLine_q;
   assign txBusy = (tx_q != TX_IDLE);
   assign txDone = done_q;

   // =====================================================
   // checks
   property p_idle_ones;
      @(posedge clk_sys) disable iff (!arst_n)
      (!indOn && rOnes && !rFlags_q) |=> (chan_q == CH_IDLE);
   endproperty
   a_idle_ones: assert property (p_idle_ones) else $error("idle not decoded");
   property p_data_rx;
      @(posedge clk_sys) disable iff (!arst_n)
      (indOn && rFlags_q && chan_q != CH_IDLE && chan_q != CH_OWN_TX) |=> (chan_q == CH_DATA_RX);
   endproperty
   a_data_rx: assert property (p_data_rx) else $error("data reception not decoded");
   property p_voice_bound;
      @(posedge clk_sys) disable iff (!arst_n)
      (chan_q == CH_VOICE && $past(chan_q) == CH_BUSY_UNKNOWN)
         |-> ($past(busyMs_q) == BUSY_MS_W'(VOICE_WINDOW_MS - 1));
   endproperty
   a_voice_bound: assert property (p_voice_bound) else $error("voice decided at wrong time");
   property p_busy_unknown;
      @(posedge clk_sys) disable iff (!arst_n)
      (chan_q == CH_BUSY_UNKNOWN)
         |-> (status.busy && !status.voice && busyMs_q < BUSY_MS_W'(VOICE_WINDOW_MS));
   endproperty
   a_busy_unknown: assert property (p_busy_unknown) else $error("undetermined busy wrong");
   property p_key_clear;
      @(posedge clk_sys) disable iff (!arst_n)
      $rose(ctrl_q) |-> $past(!indOn && rOnes);
   endproperty
   a_key_clear: assert property (p_key_clear) else $error("keyed on busy channel");
   property p_data_start;
      @(posedge clk_sys) disable iff (!arst_n)
      (tx_q == TX_DATA && $past(tx_q) == TX_FLAGS) |-> $past(!indOn && rFlags_q);
   endproperty
   a_data_start: assert property (p_data_start) else $error("data before flag echo");
   property p_release;
      @(posedge clk_sys) disable iff (!arst_n)
      (tx_q == TX_TAIL && bitStb) |=> (!ctrl_q && tLine_q && tx_q == TX_IDLE);
   endproperty
   a_release: assert property (p_release) else $error("release not done");
   property p_adjust;
      @(posedge clk_sys) disable iff (!arst_n)
      adjValid_q |-> (chan_q == CH_VOICE && adjMs_q == BUSY_MS_W'(VOICE_WINDOW_MS));
   endproperty
   a_adjust: assert property (p_adjust) else $error("adjust value wrong");
   property p_suspend;
      @(posedge clk_sys) disable iff (!arst_n)
      (status.busy && !status.voice) |-> !status.suspend;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspended before voice");
   property p_prec_first;
      @(posedge clk_sys) disable iff (!arst_n)
      precWr_q |-> !ctrl_q;
   endproperty
   a_prec_first: assert property (p_prec_first) else $error("keyed before precedence set");
   property p_prec_max;
      @(posedge clk_sys) disable iff (!arst_n)
      (frmPrecValid && tx_q != TX_IDLE) |=> (maxPrec_q >= $past(frmPrec));
   endproperty
   a_prec_max: assert property (p_prec_max) else $error("precedence not maximum");
   property p_tick;
      @(posedge clk_sys) disable iff (!arst_n)
      msTick_q |=> !msTick_q;
   endproperty
   a_tick: assert property (p_tick) else $error("tick longer than one cycle");

endmodule : rnb_net_busy

// File: core/rnb_pkg.sv
// How it works
// - indication off with ones is idle; indication off with flags is own transmission.
// - indication on with ones beyond 750 ms is classified as voice.
// - first 750 ms of indication on with ones is busy, type undetermined.
// - check indication off and ones, then raise push-to-talk and send flags.
// - with indication off and flags echoed, start sending data bits.
// - after the last data bit, drop push-to-talk and send ones.
// - busy-to-voice interval is added to every suspended access timer.
// - access timers are suspended only once busy with voice is known.
// - a changed precedence is programmed into the radio before keying.
// - programmed precedence is the highest among concatenated frames.
// - slot width is 18 ms hop mode, 54 ms single channel mode.
package rnb_pkg;
   // =====================================================
   // timing
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned CLKS_PER_MS    = CLK_MHZ * 1000;
   localparam int unsigned VOICE_WINDOW_MS = 750;
   localparam int unsigned SLOT_HOP_MS    = 18;
   localparam int unsigned SLOT_SINGLE_MS = 54;
   localparam int unsigned BUSY_MS_W      = 16;
   // =====================================================
   // line patterns
   localparam logic [7:0]  FLAG_PATTERN   = 8'h7E;
   localparam logic [3:0]  ONES_RUN_MIN   = 4'h8;
   localparam logic [2:0]  PREC_RESET     = 3'h0;
   // =====================================================
   // types
   typedef enum logic [2:0] {
      CH_IDLE,
      CH_OWN_TX,
      CH_BUSY_UNKNOWN,
      CH_DATA_RX,
      CH_VOICE
   } rnb_chan_type;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_PREC,
      TX_WAIT_CLEAR,
      TX_FLAGS,
      TX_DATA,
      TX_TAIL
   } rnb_tx_type;

   typedef struct packed {
      rnb_chan_type chan;
      logic         busy;
      logic         voice;
      logic         suspend;
   } rnb_status_type;

   typedef struct packed {
      logic                 valid;
      logic [BUSY_MS_W-1:0] addMs;
   } rnb_adjust_type;
endpackage : rnb_pkg

// File: verif/rnb_radio_model.sv
`timescale 1ns/10ps
// =====================================================
// radio side: bit timing, indication, receive line, precedence ack
module rnb_radio_model
(
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic [1:0] mode,
   input  wire logic       ctrlOn,
   input  wire logic       precWrValid,
   output      logic       bitStb,
   output      logic       indOn,
   output      logic       rxBit,
   output      logic       precWrReady
);
   import rnb_pkg::*;
   logic [1:0] divQ;
   logic [7:0] flagQ;

   // mode 0 idle, 1 data reception, 2 voice
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         divQ        <= 2'h0;
         bitStb      <= 1'b0;
         indOn       <= 1'b0;
         rxBit       <= 1'b1;
         flagQ       <= FLAG_PATTERN;
         precWrReady <= 1'b0;
      end
      else
      begin
         divQ        <= divQ + 2'h1;
         bitStb      <= (divQ == 2'h3);
         indOn       <= (mode != 2'h0);
         precWrReady <= precWrValid && !precWrReady;
         if (bitStb)
         begin
            flagQ <= {flagQ[6:0], flagQ[7]};
            // flags on reception, echo of own flags, else ones
            rxBit <= (mode == 2'h1 || (mode == 2'h0 && ctrlOn)) ? flagQ[7] : 1'b1;
         end
      end
   end
endmodule : rnb_radio_model

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
   import rnb_pkg::*;
   logic clk_sys = 1'b0, arst_n = 1'b0, hop = 1'b1, txReq = 1'b0;
   logic dValid = 1'b0, dBit = 1'b0, dLast = 1'b0, fpValid = 1'b0;
   logic [2:0] fPrec = 3'h0;
   logic [1:0] mode = 2'h0;
   logic bitStb, indOn, rxBit, txDataReady, precWrValid, precWrReady;
   logic ctrlOn, txLine, txBusy, txDone;
   logic [2:0] precWrValue;
   logic [5:0] slotWidthMs;
   rnb_status_type status;
   rnb_adjust_type timerAdjust;
   int badCount = 0, nChecks = 0, cycles = 0, n;

   always #2.5 clk_sys = ~clk_sys;

   rnb_net_busy #(.MS_DIVIDE(10)) rnb_net_busy_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .bitStb(bitStb), .indOn(indOn),
      .rxBit(rxBit), .frequency_hop_mode(hop), .txReq(txReq),
      .txDataValid(dValid), .txDataBit(dBit), .txDataLast(dLast),
      .txDataReady(txDataReady), .frmPrecValid(fpValid), .frmPrec(fPrec),
      .precWrValid(precWrValid), .precWrValue(precWrValue),
      .precWrReady(precWrReady), .ctrlOn(ctrlOn), .txLine(txLine),
      .txBusy(txBusy), .txDone(txDone), .slotWidthMs(slotWidthMs),
      .status(status), .timerAdjust(timerAdjust));

   rnb_radio_model rnb_radio_model_i (
      .clk_sys(clk_sys), .arst_n(arst_n), .mode(mode), .ctrlOn(ctrlOn),
      .precWrValid(precWrValid), .bitStb(bitStb), .indOn(indOn),
      .rxBit(rxBit), .precWrReady(precWrReady));

   // =====================================================
   // checking and closing
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         badCount++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d errors %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         badCount++;
         end_of_test();
      end
   end

   // =====================================================
   // scenarios
   task automatic toMode(input logic [1:0] m);
      @(posedge clk_sys);
      mode <= m;
   endtask : toMode

   task automatic slotTest();
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk_sys);
         hop <= i[0];
         #1 chk(slotWidthMs, i[0] ? 16'h0012 : 16'h0036);
      end
   endtask : slotTest

   task automatic voiceTest();
      toMode(2'h2);
      repeat (40) @(posedge clk_sys);
      chk({status.chan, status.busy, status.voice, status.suspend},
          {CH_BUSY_UNKNOWN, 3'b100});
      n = 40;
      while (timerAdjust.valid !== 1'b1 && n < 9000)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk(n >= 7480 && n <= 7540, 1);
      chk(timerAdjust.addMs, 16'h02EE);
      chk({status.chan, status.suspend}, {CH_VOICE, 1'b1});
   endtask : voiceTest

   task automatic dataRxTest();
      toMode(2'h1);
      n = 0;
      while (status.chan !== CH_DATA_RX && n < 300)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk(status.chan, CH_DATA_RX);
      toMode(2'h0);
      repeat (80) @(posedge clk_sys);
      chk(status.chan, CH_IDLE);
   endtask : dataRxTest

   task automatic sendBits(input logic [15:0] d, input int nb);
      n = 0;
      while (ctrlOn !== 1'b1 && n < 2000)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk(ctrlOn, 1);
      @(posedge clk_sys);
      dValid <= 1'b1;
      dBit <= d[nb-1];
      dLast <= (nb == 1);
      for (int i = nb - 1; i >= 0; i--)
      begin
         n = 0;
         do @(negedge clk_sys); while (txDataReady !== 1'b1 && ++n < 2000);
         if (i == nb - 1)
            chk(status.chan, CH_OWN_TX);
         @(posedge clk_sys);
         dBit <= (i > 0) ? d[i-1] : 1'b0;
         dLast <= (i == 1);
         dValid <= (i > 0);
         #1 chk(txLine, d[i]);
      end
      n = 0;
      while (txDone !== 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk({txDone, ctrlOn, txLine, txBusy}, 4'b1010);
   endtask : sendBits

   task automatic keyTest();
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_sys);
         fpValid <= 1'b1;
         fPrec <= (i == 1) ? 3'h5 : 3'(4 - 2 * i);
      end
      @(posedge clk_sys);
      fpValid <= 1'b0;
      txReq <= 1'b1;
      @(posedge clk_sys);
      txReq <= 1'b0;
      n = 0;
      while (precWrValid !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk({precWrValid, precWrValue, ctrlOn}, 5'b1_101_0);
      sendBits(16'hA5C3, 12);
   endtask : keyTest

   task automatic blockedTest();
      toMode(2'h2);
      repeat (40) @(posedge clk_sys);
      txReq <= 1'b1;
      @(posedge clk_sys);
      txReq <= 1'b0;
      repeat (300) @(posedge clk_sys);
      chk({txBusy, ctrlOn, txLine}, 3'b101);
      fpValid <= 1'b1;
      fPrec <= 3'h6;
      @(posedge clk_sys);
      fpValid <= 1'b0;
      toMode(2'h0);
      sendBits(16'h0002, 2);
      @(posedge clk_sys);
      txReq <= 1'b1;
      @(posedge clk_sys);
      txReq <= 1'b0;
      n = 0;
      while (precWrValid !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         n++;
      end
      chk({precWrValid, precWrValue}, 4'b1_110);
      sendBits(16'h0001, 1);
   endtask : blockedTest

   initial
   begin
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      #1 chk({ctrlOn, txLine, precWrValid, txDone, status.chan}, {4'b0100, CH_IDLE});
      slotTest();
      voiceTest();
      dataRxTest();
      keyTest();
      blockedTest();
      end_of_test();
   end
endmodule : tb
